//--- phy_mgmt_regs.vh
`ifndef PHY_MGMT_REGS_VH
`define PHY_MGMT_REGS_VH
// Serial register indices
`define IDX_BASIC_CTRL   5'h00
`define IDX_BASIC_STAT   5'h01
`define IDX_ID_HIGH      5'h02
`define IDX_ID_LOW       5'h03
`define IDX_NEG_ADVERT   5'h04
`define IDX_PARTNER      5'h05
`define IDX_NEG_EXPAN    5'h06
`define IDX_ENERGY_DETECT_POWERDOWN_CFG     5'h10
`define IDX_MODE_CTRL    5'h11
`define IDX_SPEC_MODES   5'h12
`define IDX_SPEC_IND     5'h1b
`define IDX_IRQ_SRC      5'h1d
`define IDX_IRQ_MASK     5'h1e
`define IDX_SPEC_CTRL    5'h1f
// Basic control field positions
`define BC_RESET         15
`define BC_LOOPBACK      14
`define BC_SPEED         13
`define BC_AUTONEG       12
`define BC_PWRDN         11
`define BC_RESTART       9
`define BC_DUPLEX        8
`define BC_COLTEST       7
// Writable basic control bits
`define BC_WMASK         16'hfb80
// Basic status fixed part and field positions
`define BS_FIXED         16'h7809
`define BS_NEG_DONE      5
`define BS_LINK          2
// Reset values of other writable registers
`define ADVERT_RST       16'h01e1
`define ZERO16           16'h0000
// Indirect access register fields
`define ACC_BUSY         0
`define ACC_WRITE        1
// Negotiation model time: 2 ms at 10 MHz
`define NEG_TIME_US      2000
`define NEG_CYCLES       ((`NEG_TIME_US * 10))
// Frame: 32 preamble ones, start 01
`define MDIO_PREAMBLE    6'd32
`endif

//--- xcvr_regs.v
`timescale 1ns/1ns
`include "phy_mgmt_regs.vh"
module xcvr_regs #(
    parameter NEG_CYCLES = `NEG_CYCLES
) (
    input  wire        ref_clk_i,     // System clock
    input  wire        rst_n_i,       // Async reset, active low
    input  wire        straps_ok_i,   // Straps captured
    input  wire        strap_an_i,    // Autoneg strap
    input  wire        strap_spd_i,   // Speed strap
    input  wire        strap_dup_i,   // Duplex strap
    input  wire        load_i,        // Loader rewrite strobe
    input  wire [15:0] load_data_i,   // Loader value
    input  wire        wr_i,          // Register write strobe
    input  wire [4:0]  idx_i,         // Register index
    input  wire [15:0] wdata_i,       // Write data
    input  wire        link_up_i,     // Line link level
    output reg  [15:0] rdata_o,       // Read data
    output wire [15:0] ctrl_o         // Basic control value
);
    reg [15:0] ctrl_ff;
    reg [15:0] adv_ff;
    reg [15:0] energy_detect_powerdown_ff;
    reg [15:0] mode_ff;
    reg [15:0] spec_ff;
    reg [15:0] mask_ff;
    reg [15:0] src_ff;
    reg        done_ff;
    reg        rst_pend_ff;
    reg [31:0] neg_cnt_ff;
    wire [15:0] dflt_ctrl;
    wire        ctrl_wr;

    assign dflt_ctrl = {2'b00, strap_an_i | strap_spd_i, strap_an_i, 3'b000,
                        ~strap_an_i & strap_dup_i, 8'h00};
    assign ctrl_wr = wr_i && idx_i == `IDX_BASIC_CTRL;
    assign ctrl_o  = ctrl_ff;

    // Negotiation finishes on this edge; source flag not cleared on read
    wire neg_done_nxt = !ctrl_ff[`BC_PWRDN] && ctrl_ff[`BC_AUTONEG] &&
                        !ctrl_ff[`BC_RESTART] && !rst_pend_ff &&
                        neg_cnt_ff >= NEG_CYCLES - 1;
    wire rd_src_clr = 1'b0;

    // ------------------------------------------------------------
    // Writable registers and soft reset
    // ------------------------------------------------------------
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_ff     <= `ZERO16;
            adv_ff      <= `ADVERT_RST;
            energy_detect_powerdown_ff     <= `ZERO16;
            mode_ff     <= `ZERO16;
            spec_ff     <= `ZERO16;
            mask_ff     <= `ZERO16;
            rst_pend_ff <= 1'b1;
        end else if (rst_pend_ff) begin
            // Defaults follow straps; special modes is soft-reset immune
            if (straps_ok_i) begin
                ctrl_ff     <= dflt_ctrl;
                adv_ff      <= `ADVERT_RST;
                energy_detect_powerdown_ff     <= `ZERO16;
                mode_ff     <= `ZERO16;
                mask_ff     <= `ZERO16;
                rst_pend_ff <= 1'b0;
            end
        end else if (load_i) begin
            ctrl_ff <= load_data_i & `BC_WMASK;
        end else if (wr_i) begin
            case (idx_i)
                `IDX_BASIC_CTRL: begin
                    ctrl_ff <= wdata_i & `BC_WMASK;
                    rst_pend_ff <= wdata_i[`BC_RESET];
                end
                `IDX_NEG_ADVERT: adv_ff  <= wdata_i;
                `IDX_ENERGY_DETECT_POWERDOWN_CFG:   energy_detect_powerdown_ff <= wdata_i;
                `IDX_MODE_CTRL:  mode_ff <= wdata_i;
                `IDX_SPEC_MODES: spec_ff <= wdata_i;
                `IDX_IRQ_MASK:   mask_ff <= wdata_i;
                default: ;
            endcase
        end else if (ctrl_ff[`BC_RESTART]) begin
            ctrl_ff[`BC_RESTART] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Negotiation model and event flags
    // ------------------------------------------------------------
    // Restart or power-up re-runs it; a real line takes far longer
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            neg_cnt_ff <= 32'h0;
            done_ff    <= 1'b0;
            src_ff     <= `ZERO16;
        end else begin
            if (ctrl_ff[`BC_PWRDN] || !ctrl_ff[`BC_AUTONEG] ||
                ctrl_ff[`BC_RESTART] || rst_pend_ff) begin
                neg_cnt_ff <= 32'h0;
                done_ff    <= 1'b0;
            end else if (neg_cnt_ff < NEG_CYCLES - 1) begin
                neg_cnt_ff <= neg_cnt_ff + 32'h1;
            end else begin
                done_ff <= 1'b1;
            end
            // Set wins over clear-on-read
            if (rd_src_clr)
                src_ff <= {9'h0, ~done_ff & neg_done_nxt, 6'h0};
            else if (~done_ff & neg_done_nxt)
                src_ff[6] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read decode; undecoded indices read zero
    // ------------------------------------------------------------
    always @* begin
        case (idx_i)
            `IDX_BASIC_CTRL: rdata_o = ctrl_ff;
            `IDX_BASIC_STAT: rdata_o = `BS_FIXED | {10'h0, done_ff, 2'b00,
                                       link_up_i & ~ctrl_ff[`BC_PWRDN], 2'b00};
            `IDX_ID_HIGH:    rdata_o = `ZERO16;
            `IDX_ID_LOW:     rdata_o = `ZERO16;
            `IDX_NEG_ADVERT: rdata_o = adv_ff;
            `IDX_PARTNER:    rdata_o = `ZERO16;
            `IDX_NEG_EXPAN:  rdata_o = `ZERO16;
            `IDX_ENERGY_DETECT_POWERDOWN_CFG:   rdata_o = energy_detect_powerdown_ff;
            `IDX_MODE_CTRL:  rdata_o = mode_ff;
            `IDX_SPEC_MODES: rdata_o = spec_ff;
            `IDX_SPEC_IND:   rdata_o = `ZERO16;
            `IDX_IRQ_SRC:    rdata_o = src_ff;
            `IDX_IRQ_MASK:   rdata_o = mask_ff;
            `IDX_SPEC_CTRL:  rdata_o = `ZERO16;
            default:         rdata_o = `ZERO16;
        endcase
    end
endmodule // xcvr_regs

//--- port_phy_mgmt_registers.v
`timescale 1ns/1ns
`include "phy_mgmt_regs.vh"
module port_phy_mgmt_registers #(
    parameter [4:0] PORT1_ADDR = 5'h01,  // Arbitrary default address
    parameter [4:0] PORT2_ADDR = 5'h02,  // Arbitrary default address
    parameter [4:0] VPHY_ADDR  = 5'h00,  // Arbitrary default address
    parameter       NEG_CYCLES = `NEG_CYCLES
) (
    input  wire        ref_clk_i,      // 10 MHz clock
    input  wire        rst_n_i,        // Async reset, active low
    input  wire        serial_mode_i,  // 1: serial mode, 0: I2C mode
    input  wire [2:0]  strap_an_i,     // Autoneg straps per port
    input  wire [2:0]  strap_spd_i,    // Speed straps per port
    input  wire [2:0]  strap_dup_i,    // Duplex straps per port
    input  wire        load_i,         // Loader rewrite strobe
    input  wire [1:0]  load_port_i,    // Loader target port
    input  wire [15:0] load_data_i,    // Loader control value
    input  wire        acc_wr_i,       // Indirect access write
    input  wire [15:0] acc_wdata_i,    // {addr,idx,..,write,busy}
    input  wire        dat_wr_i,       // Indirect data write
    input  wire [15:0] dat_wdata_i,    // Indirect data value
    input  wire        vmap_wr_i,      // Memory-map write, emulated port
    input  wire [4:0]  vmap_idx_i,     // Memory-map index
    input  wire [15:0] vmap_wdata_i,   // Memory-map data
    input  wire        mdc_i,          // Management clock pin
    input  wire        mdio_i,         // Management data pin in
    input  wire [1:0]  link_up_i,      // Line link levels
    output reg  [15:0] acc_rdata_o,    // Indirect access readback
    output reg  [15:0] dat_rdata_o,    // Indirect data readback
    output reg  [15:0] vmap_rdata_o,   // Memory-map read data
    output reg         mdio_o,         // Management data pin out
    output reg         mdio_oe_o,      // Management data enable
    output reg  [1:0]  loopback_o,     // Per-port loopback
    output reg  [1:0]  speed100_o,     // Per-port 100 Mbps
    output reg  [1:0]  full_dup_o,     // Per-port full duplex
    output reg  [1:0]  power_down_o    // Per-port power-down
);
    // ------------------------------------------------------------
    // Pin synchronisers and strap capture
    // ------------------------------------------------------------
    reg [1:0] mdc_sync_ff;
    reg [1:0] mdio_sync_ff;
    reg       mdc_prev_ff;
    reg       straps_ok_ff;
    reg [2:0] an_ff;
    reg [2:0] spd_ff;
    reg [2:0] dup_ff;

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdc_sync_ff  <= 2'b00;
            mdio_sync_ff <= 2'b11;
            mdc_prev_ff  <= 1'b0;
            straps_ok_ff <= 1'b0;
            an_ff        <= 3'b000;
            spd_ff       <= 3'b000;
            dup_ff       <= 3'b000;
        end else begin
            mdc_sync_ff  <= {mdc_sync_ff[0], mdc_i};
            mdio_sync_ff <= {mdio_sync_ff[0], mdio_i};
            mdc_prev_ff  <= mdc_sync_ff[1];
            // Straps caught once at release, not under reset
            if (!straps_ok_ff) begin
                an_ff  <= strap_an_i;
                spd_ff <= strap_spd_i;
                dup_ff <= strap_dup_i;
                straps_ok_ff <= 1'b1;
            end
        end
    end
    wire mdc_rise = mdc_sync_ff[1] & ~mdc_prev_ff;
    wire mdc_fall = ~mdc_sync_ff[1] & mdc_prev_ff;
    wire mdio_s   = mdio_sync_ff[1];

    // ------------------------------------------------------------
    // Clause 22 frame engine
    // ------------------------------------------------------------
    localparam ST_PRE  = 3'd0;
    localparam ST_HDR  = 3'd1;
    localparam ST_TA   = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_IDLE = 3'd4;

    reg [2:0]  st_ff;
    reg [5:0]  cnt_ff;
    reg [13:0] hdr_ff;
    reg [15:0] sh_ff;
    reg        own_ff;

    // hdr: start(2) op(2) phyaddr(5) regidx(5)
    wire [1:0] op_s   = hdr_ff[11:10];
    wire [4:0] fr_adr = hdr_ff[9:5];
    wire [4:0] fr_idx = hdr_ff[4:0];
    wire       fr_rd  = op_s == 2'b10;
    wire       ser_wr = serial_mode_i && st_ff == ST_DATA && mdc_rise &&
                        cnt_ff == 6'd15 && !fr_rd;

    // Indirect access state; busy bit clears after one cycle
    reg [15:0] acc_ff;
    reg [15:0] dat_ff;
    reg        ind_go_ff;

    wire [4:0] ind_adr = acc_ff[15:11];
    wire [4:0] ind_idx = acc_ff[10:6];

    // Selected port and index for the shared register view
    wire [4:0]  sel_adr = serial_mode_i ? fr_adr : ind_adr;
    wire [4:0]  sel_idx = serial_mode_i ? fr_idx : ind_idx;
    wire        ind_wr  = !serial_mode_i && ind_go_ff && acc_ff[`ACC_WRITE];
    wire [15:0] sel_wd  = serial_mode_i ? {sh_ff[14:0], mdio_s} : dat_ff;
    wire [2:0]  hit = {sel_adr == VPHY_ADDR, sel_adr == PORT2_ADDR,
                       sel_adr == PORT1_ADDR};
    // Read data of the addressed set; foreign addresses read zero
    wire [15:0] rd0, rd1, rd2, vrd, ctl0, ctl1, ctl2;
    wire [15:0] sel_rd = hit[0] ? rd0 : hit[1] ? rd1 : hit[2] ? rd2 :
                         `ZERO16;

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff     <= ST_PRE;
            cnt_ff    <= 6'd0;
            hdr_ff    <= 14'h0;
            sh_ff     <= `ZERO16;
            own_ff    <= 1'b0;
            mdio_o    <= 1'b1;
            mdio_oe_o <= 1'b0;
        end else if (!serial_mode_i) begin
            st_ff     <= ST_PRE;
            mdio_oe_o <= 1'b0;
        end else begin
            case (st_ff)
                ST_PRE: if (mdc_rise) begin
                    cnt_ff <= mdio_s ? cnt_ff + 6'd1 : 6'd0;
                    if (!mdio_s && cnt_ff >= `MDIO_PREAMBLE) begin
                        st_ff  <= ST_HDR;
                        hdr_ff <= 14'h0;
                        cnt_ff <= 6'd1;
                    end
                end
                ST_HDR: if (mdc_rise) begin
                    hdr_ff <= {hdr_ff[12:0], mdio_s};
                    cnt_ff <= cnt_ff + 6'd1;
                    if (cnt_ff == 6'd13) begin
                        st_ff  <= ST_TA;
                        cnt_ff <= 6'd0;
                    end
                end
                ST_TA: begin
                    own_ff <= |hit;
                    // Read: release for bit one, drive zero on second
                    if (mdc_fall && fr_rd && |hit && cnt_ff == 6'd1) begin
                        mdio_o    <= 1'b0;
                        mdio_oe_o <= 1'b1;
                        sh_ff     <= sel_rd;
                    end
                    if (mdc_rise) begin
                        cnt_ff <= cnt_ff + 6'd1;
                        if (cnt_ff == 6'd1) begin
                            st_ff  <= ST_DATA;
                            cnt_ff <= 6'd0;
                        end
                    end
                end
                ST_DATA: begin
                    if (mdc_fall && fr_rd && own_ff) begin
                        mdio_o <= sh_ff[15];
                        sh_ff  <= {sh_ff[14:0], 1'b0};
                    end
                    if (mdc_rise) begin
                        if (!fr_rd)
                            sh_ff <= {sh_ff[14:0], mdio_s};
                        cnt_ff <= cnt_ff + 6'd1;
                        if (cnt_ff == 6'd15)
                            st_ff <= ST_IDLE;
                    end
                end
                ST_IDLE: if (mdc_fall) begin
                    mdio_oe_o <= 1'b0;
                    mdio_o    <= 1'b1;
                    st_ff     <= ST_PRE;
                    cnt_ff    <= 6'd0;
                end
                default: st_ff <= ST_PRE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Indirect access/data pair, runs in both modes; register writes through it in I2C mode only
    // ------------------------------------------------------------
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_ff    <= `ZERO16;
            dat_ff    <= `ZERO16;
            ind_go_ff <= 1'b0;
        end else begin
            ind_go_ff <= 1'b0;
            if (ind_go_ff) begin
                acc_ff[`ACC_BUSY] <= 1'b0;
                if (!acc_ff[`ACC_WRITE])
                    dat_ff <= sel_rd;
            end else if (acc_wr_i && !acc_ff[`ACC_BUSY]) begin
                acc_ff    <= acc_wdata_i;
                ind_go_ff <= acc_wdata_i[`ACC_BUSY];
            end
            if (dat_wr_i && !acc_ff[`ACC_BUSY])
                dat_ff <= dat_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Three register sets: ports 1, 2 and the emulated port
    // ------------------------------------------------------------
    wire [2:0]  wr_v = hit & {3{ser_wr | ind_wr}};

    xcvr_regs #(.NEG_CYCLES(NEG_CYCLES)) u_port1 (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .straps_ok_i(straps_ok_ff), .strap_an_i(an_ff[0]),
        .strap_spd_i(spd_ff[0]), .strap_dup_i(dup_ff[0]),
        .load_i(load_i && load_port_i == 2'd1),
        .load_data_i(load_data_i), .wr_i(wr_v[0]), .idx_i(sel_idx),
        .wdata_i(sel_wd), .link_up_i(link_up_i[0]),
        .rdata_o(rd0), .ctrl_o(ctl0));
    xcvr_regs #(.NEG_CYCLES(NEG_CYCLES)) u_port2 (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .straps_ok_i(straps_ok_ff), .strap_an_i(an_ff[1]),
        .strap_spd_i(spd_ff[1]), .strap_dup_i(dup_ff[1]),
        .load_i(load_i && load_port_i == 2'd2),
        .load_data_i(load_data_i), .wr_i(wr_v[1]), .idx_i(sel_idx),
        .wdata_i(sel_wd), .link_up_i(link_up_i[1]),
        .rdata_o(rd1), .ctrl_o(ctl1));
    // Emulated port: shared register view plus memory-map port, shared view wins
    wire [4:0] v_idx = wr_v[2] ? sel_idx : (hit[2] ? sel_idx : vmap_idx_i);
    xcvr_regs #(.NEG_CYCLES(NEG_CYCLES)) u_vphy (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .straps_ok_i(straps_ok_ff), .strap_an_i(an_ff[2]),
        .strap_spd_i(spd_ff[2]), .strap_dup_i(dup_ff[2]),
        .load_i(1'b0), .load_data_i(load_data_i),
        .wr_i(wr_v[2] | (vmap_wr_i & ~hit[2])),
        .idx_i(v_idx), .wdata_i(wr_v[2] ? sel_wd : vmap_wdata_i),
        .link_up_i(1'b1), .rdata_o(rd2), .ctrl_o(ctl2));
    assign vrd = rd2;

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_rdata_o  <= `ZERO16;
            dat_rdata_o  <= `ZERO16;
            vmap_rdata_o <= `ZERO16;
            loopback_o   <= 2'b00;
            speed100_o   <= 2'b00;
            full_dup_o   <= 2'b00;
            power_down_o <= 2'b00;
        end else begin
            acc_rdata_o  <= acc_ff;
            dat_rdata_o  <= dat_ff;
            vmap_rdata_o <= vrd;
            loopback_o   <= {ctl1[`BC_LOOPBACK], ctl0[`BC_LOOPBACK]};
            power_down_o <= {ctl1[`BC_PWRDN], ctl0[`BC_PWRDN]};
            // Negotiated link assumed 100 full when autoneg is on
            speed100_o <= {ctl1[`BC_SPEED] | ctl1[`BC_AUTONEG],
                           ctl0[`BC_SPEED] | ctl0[`BC_AUTONEG]};
            full_dup_o <= {ctl1[`BC_DUPLEX] | ctl1[`BC_AUTONEG],
                           ctl0[`BC_DUPLEX] | ctl0[`BC_AUTONEG]};
        end
    end
endmodule // port_phy_mgmt_registers

//--- port_phy_mgmt_checker.sv
`timescale 1ns/1ns
module port_phy_mgmt_checker (
    input wire logic        ref_clk_i,     // Clock
    input wire logic        rst_n_i,       // Reset, active low
    input wire logic        serial_mode_i, // Serial mode select
    input wire logic        load_i,        // Loader strobe
    input wire logic        acc_wr_i,      // Access write
    input wire logic [15:0] acc_wdata_i,   // Access word
    input wire logic        dat_wr_i,      // Data write
    input wire logic [15:0] acc_rdata_o,   // Access readback
    input wire logic [15:0] dat_rdata_o,   // Data readback
    input wire logic        mdio_oe_o,     // Data pin enable
    input wire logic [1:0]  loopback_o,    // Loopback outputs
    input wire logic [1:0]  power_down_o   // Power-down outputs
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // -------------------------------------------------
    // Cycles since the last host or loader request
    // -------------------------------------------------
    logic [3:0] age_ff;
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            age_ff <= 4'hf;
        else if (acc_wr_i | dat_wr_i | load_i)
            age_ff <= 4'h0;
        else if (age_ff != 4'hf)
            age_ff <= age_ff + 4'h1;
    end
    io_mode_a: assert property (!serial_mode_i && !$past(serial_mode_i)
        |-> !mdio_oe_o) else $error("data pin driven in indirect mode");
    busy_clear_a: assert property (acc_wr_i && acc_wdata_i[0]
        && !acc_rdata_o[0] |-> ##2 acc_rdata_o[0] ##1 !acc_rdata_o[0])
        else $error("access busy did not clear");
    busy_idle_a: assert property (!acc_rdata_o[0] && !acc_wr_i
        && !$past(acc_wr_i)
        |=> !acc_rdata_o[0]) else $error("busy set without access");
    loop_cause_a: assert property ($changed(loopback_o)
        && !serial_mode_i |-> age_ff < 4'h5)
        else $error("loopback changed without request");
    pdown_cause_a: assert property ($changed(power_down_o)
        && !serial_mode_i |-> age_ff < 4'h5)
        else $error("power-down changed without request");
    data_cause_a: assert property ($changed(dat_rdata_o)
        && !serial_mode_i |-> age_ff < 4'h8)
        else $error("data readback changed without request");
    oe_hold_a: assert property ($rose(mdio_oe_o)
        |-> mdio_oe_o [*8]) else $error("read drive too short");
    oe_mode_a: assert property ($rose(mdio_oe_o)
        |-> serial_mode_i) else $error("frame answered in wrong mode");
endmodule // port_phy_mgmt_checker

//--- mgmt_host.sv
`timescale 1ns/1ns
module mgmt_host (
    input  wire logic ref_clk_i, // System clock
    input  wire logic line_i,    // Resolved data line
    output logic      mdc_o,     // Management clock
    output logic      mdio_o,    // Data driven
    output logic      mdio_oe_o  // Drive enable
);
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end
    // One frame, clock idle low between frames; period 10 clocks
    task automatic xfer(input logic rd, input logic [4:0] pa, ra,
                        input logic [15:0] wd, output logic [15:0] q);
        logic [63:0] bits;
        bits = {32'hffff_ffff, 2'b01, rd, !rd, pa, ra, 2'b10, wd};
        q = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            mdio_oe_o <= !(rd && i < 18); // Released from turnaround on
            mdio_o    <= bits[i];
            repeat (5) @(posedge ref_clk_i);
            if (i < 16) q[i] = line_i;
            mdc_o <= 1'b1;
            repeat (5) @(posedge ref_clk_i);
            mdc_o <= 1'b0;
        end
        mdio_oe_o <= 1'b0;
        @(posedge ref_clk_i); // Next frame must not drive in same step
    endtask
endmodule // mgmt_host

//--- port_phy_mgmt_registers_tb_top.sv
`timescale 1ns/1ns
`include "phy_mgmt_regs.vh"
module port_phy_mgmt_registers_tb_top;
    logic        ref_clk_i, rst_n_i, serial_mode_i, load_i, acc_wr_i;
    logic        dat_wr_i, mdio_o, mdio_oe_o, mdc, h_d, h_oe, line;
    logic [2:0]  an_s, st;
    logic [1:0]  load_port_i, lk;
    logic [15:0] load_data_i, acc_wdata_i, dat_wdata_i, q;
    logic [15:0] acc_rdata_o, dat_rdata_o;
    logic [1:0]  loopback_o, speed100_o, full_dup_o, power_down_o;
    logic        vmap_wr;
    logic [4:0]  vmap_idx;
    logic [15:0] vmap_wd, vmap_rd;
    int          n_fail, samples_checked, cyc;
    assign line = mdio_oe_o ? mdio_o : (h_oe ? h_d : 1'b1); // Pull-up
    port_phy_mgmt_registers #(.NEG_CYCLES(8)) port_phy_mgmt_registers_inst (
        .ref_clk_i, .rst_n_i, .serial_mode_i, .strap_an_i(an_s),
        .strap_spd_i(st), .strap_dup_i(st), .load_i, .load_port_i,
        .load_data_i, .acc_wr_i, .acc_wdata_i, .dat_wr_i, .dat_wdata_i,
        .vmap_wr_i(vmap_wr), .vmap_idx_i(vmap_idx), .vmap_wdata_i(vmap_wd),
        .mdc_i(mdc), .mdio_i(line), .link_up_i(lk), .acc_rdata_o,
        .dat_rdata_o, .vmap_rdata_o(vmap_rd), .mdio_o, .mdio_oe_o, .loopback_o,
        .speed100_o, .full_dup_o, .power_down_o);
    mgmt_host mgmt_host_inst (.ref_clk_i(ref_clk_i), .line_i(line),
        .mdc_o(mdc), .mdio_o(h_d), .mdio_oe_o(h_oe));
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task chk(input logic [15:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("Error %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task wrap_up;
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Indirect cycle: data word first on writes, then access word with busy set
    task ind(input logic wr, input logic [4:0] pa, ra,
             input logic [15:0] wd, output logic [15:0] rq);
        @(posedge ref_clk_i);
        dat_wr_i <= wr;
        dat_wdata_i <= wd;
        @(posedge ref_clk_i);
        dat_wr_i <= 1'b0;
        acc_wr_i <= 1'b1;
        acc_wdata_i <= {pa, ra, 4'h0, wr, 1'b1};
        @(posedge ref_clk_i);
        acc_wr_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        #1;
        chk({15'h0, acc_rdata_o[0]}, 16'h0000);
        rq = dat_rdata_o;
    endtask
    // Control write on port 1, outputs packed {loop,speed,duplex,pdown}
    task ctl(input logic [15:0] v, input logic [7:0] e);
        ind(1'b1, 5'h01, 5'h00, v, q);
        chk({8'h0, loopback_o, speed100_o, full_dup_o, power_down_o},
            {8'h0, e});
        ind(1'b0, 5'h01, 5'h00, 16'h0000, q);
        chk(q, v & 16'hfb80 & ~16'h8200);
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up;
        end
    end
    initial begin
        {rst_n_i, serial_mode_i, load_i, acc_wr_i, dat_wr_i} = 5'h00;
        {an_s, st, load_port_i, lk} = 10'h000;
        {load_data_i, acc_wdata_i, dat_wdata_i} = 48'h0;
        {vmap_wr, vmap_idx, vmap_wd} = 22'h0;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        ctl(16'h6100, 8'h54);
        ctl(16'h1000, 8'h14);
        ctl(16'h0000, 8'h00);
        ctl(16'h0800, 8'h01);
        ctl(16'h0200, 8'h00);
        ctl(16'h1000, 8'h14);
        repeat (30) @(posedge ref_clk_i);
        ind(1'b0, 5'h01, 5'h01, 16'h0000, q);
        chk(q & 16'h0020, 16'h0020);
        ind(1'b0, 5'h01, 5'h1d, 16'h0000, q);
        chk(q & 16'h0040, 16'h0040);
        ind(1'b1, 5'h01, 5'h1e, 16'h00ff, q);
        ind(1'b1, 5'h01, 5'h04, 16'h0000, q);
        ctl(16'h4000, 8'h40);
        ctl(16'h8000, 8'h00);
        ind(1'b0, 5'h01, 5'h04, 16'h0000, q);
        chk(q, `ADVERT_RST);
        ind(1'b0, 5'h01, 5'h1e, 16'h0000, q);
        chk(q, 16'h0000);
        ind(1'b0, 5'h01, 5'h07, 16'h0000, q);
        chk(q, 16'h0000);
        // Loader rewrite of port 2 control
        @(posedge ref_clk_i);
        {load_i, load_port_i, load_data_i} <= {1'b1, 2'd2, 16'h4000};
        @(posedge ref_clk_i);
        load_i <= 1'b0;
        ind(1'b0, 5'h02, 5'h00, 16'h0000, q);
        chk({14'h0, loopback_o}, 16'h0002);
        chk(q, 16'h4000);
        // Memory-map write to the emulated port, read back both ways
        {vmap_wr, vmap_idx, vmap_wd} <= {1'b1, 5'h04, 16'h1234};
        @(posedge ref_clk_i);
        vmap_wr <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk(vmap_rd, 16'h1234);
        // Serial frames: status read, control write, foreign address
        @(posedge ref_clk_i);
        serial_mode_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        mgmt_host_inst.xfer(1'b1, 5'h01, 5'h01, 16'h0000, q);
        chk(q & 16'hffdb, `BS_FIXED & 16'hffdb);
        mgmt_host_inst.xfer(1'b1, 5'h00, 5'h04, 16'h0000, q);
        chk(q, 16'h1234);
        mgmt_host_inst.xfer(1'b0, 5'h02, 5'h00, 16'h0000, q);
        repeat (6) @(posedge ref_clk_i);
        #1;
        chk({14'h0, loopback_o}, 16'h0000);
        @(posedge ref_clk_i);
        mgmt_host_inst.xfer(1'b1, 5'h07, 5'h01, 16'h0000, q);
        chk(q, 16'hffff);
        wrap_up;
    end
endmodule // port_phy_mgmt_registers_tb_top
bind port_phy_mgmt_registers port_phy_mgmt_checker port_phy_mgmt_checker_inst (
    .ref_clk_i, .rst_n_i, .serial_mode_i, .load_i, .acc_wr_i, .acc_wdata_i,
    .dat_wr_i, .acc_rdata_o, .dat_rdata_o, .mdio_oe_o, .loopback_o,
    .power_down_o);
